// ---- verilog/plcm_ctl.sv ----
// Bits 7 to 12 of link_control_two with margin and compliance controls.
// Assumes an APB master on pclk and a state machine giving events
// synchronous to pclk; presetn is the power-on reset.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "plcm_map.svh"

module plcm_ctl (
   // Clock and resets
   input wire logic pclk,
   input wire logic presetn,
   input wire logic warm_rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link training state machine
   input wire plcm_pkg::plcm_ltssm_t ltssm,
   output plcm_pkg::plcm_tx_t tx
);
   import plcm_pkg::*;

   plcm_state_t st;
   plcm_state_t next_st;
   logic setup;
   logic wr;
   logic [31:0] lctl2_word;
   logic [31:0] stat_word;

   ////////////////////////////////////////////////////////////////////
   // Margin code to voltage pair; reserved and normal give none
   function automatic logic [19:0] margin_mv(input logic [2:0] code);
      logic [19:0] r;
      r = {`PLCM_MV_NONE, `PLCM_MV_NONE};
      unique case (code)
         3'h1: r = {`PLCM_FS1, `PLCM_LS1};
         3'h2: r = {`PLCM_FS2, `PLCM_LS2};
         3'h3: r = {`PLCM_FS3, `PLCM_LS3};
         3'h4: r = {`PLCM_FS4, `PLCM_LS4};
         3'h5: r = {`PLCM_FS5, `PLCM_LS5};
         default: r = {`PLCM_MV_NONE, `PLCM_MV_NONE};
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Read views; unlisted and reserved bits are zero
   always_comb begin
      lctl2_word = 32'h0000_0000;
      lctl2_word[`PLCM_TM_MSB:`PLCM_TM_LSB] = st.margin_sel;
      lctl2_word[`PLCM_MC_BIT] = st.mc;
      lctl2_word[`PLCM_SKP_BIT] = st.skp;
      lctl2_word[`PLCM_DE_BIT] = st.de;
      stat_word = 32'h0000_0000;
      stat_word[2:0] = st.applied;
      stat_word[3] = st.tx.use_lane_drive;
      stat_word[4] = ltssm.in_pol_comp;
      stat_word[5] = (st.applied != st.margin_sel); // Waits for retrain
   end

   assign setup = psel & ~penable;
   assign wr = psel & penable & st.pready & pwrite & ~st.pslverr;

   ////////////////////////////////////////////////////////////////////
   // Next state: bus answer, field writes, hardware updates
   always_comb begin
      next_st = st;
      // One wait-free access: answer prepared during setup
      next_st.pready = setup;
      next_st.pslverr = 1'b0;
      next_st.prdata = 32'h0000_0000;
      if (setup) begin
         if (paddr == `PLCM_LCTL2_OFS) begin
            next_st.prdata = pwrite ? 32'h0000_0000 : lctl2_word;
         end else if (paddr == `PLCM_STAT_OFS) begin
            next_st.prdata = pwrite ? 32'h0000_0000 : stat_word;
         end else begin
            next_st.pslverr = 1'b1; // Unmapped address
         end
      end
      // Writes land at the access edge; status word is read-only
      if (wr && paddr == `PLCM_LCTL2_OFS) begin
         if (pstrb[0]) begin
            next_st.margin_sel[0] = pwdata[`PLCM_TM_LSB];
         end
         if (pstrb[1]) begin
            next_st.margin_sel[2:1] = pwdata[`PLCM_TM_MSB:`PLCM_TM_LSB+1];
            next_st.mc = pwdata[`PLCM_MC_BIT];
            next_st.skp = pwdata[`PLCM_SKP_BIT];
            next_st.de = pwdata[`PLCM_DE_BIT];
         end
      end
      // Hardware clear beats a same-cycle software write
      if (ltssm.enter_pol_cfg) begin
         next_st.margin_sel = `PLCM_TM_RST;
      end
      // Old margin keeps driving until the lock state is passed
      if (ltssm.rcvr_lock) begin
         next_st.applied = st.margin_sel;
      end
      // Margin drive settings follow the applied code; compliance modes follow the fields, the override follows forced entry
      next_st.tx.margin_code = next_st.applied;
      {next_st.tx.full_mv, next_st.tx.low_mv} = margin_mv(next_st.applied);
      next_st.tx.use_lane_drive = (next_st.applied == `PLCM_TM_NORMAL) ||
         (next_st.applied > `PLCM_TM_LAST);
      next_st.tx.mod_pattern = ltssm.in_pol_comp & st.mc;
      next_st.tx.skip_insert = ltssm.in_pol_comp & st.skp;
      next_st.tx.deemph_override =
         ltssm.in_pol_comp & ltssm.comp_via_force;
      next_st.tx.deemph_35db = st.de;
      // Warm reset drops live compliance modes, not sticky fields
      if (!warm_rst_n) begin
         next_st.tx.mod_pattern = 1'b0;
         next_st.tx.skip_insert = 1'b0;
         next_st.tx.deemph_override = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register; only power-on reset clears the sticky fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.tx.use_lane_drive <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign tx = st.tx;

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_decode;
      tx.margin_code == 3'h1 |->
         tx.full_mv == 10'h384 && tx.low_mv == 10'h1f4 && !tx.use_lane_drive;
   endproperty
   a_decode: assert property (p_decode)
      else $error("margin code 1 decoded wrongly");

   property p_clear;
      ltssm.enter_pol_cfg |=> st.margin_sel == 3'h0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("margin not cleared on polling configuration");

   property p_lane;
      tx.margin_code == 3'h0 |-> tx.use_lane_drive && tx.full_mv == 10'h0;
   endproperty
   a_lane: assert property (p_lane)
      else $error("normal range not on lane drive");

   property p_hold;
      !ltssm.rcvr_lock |=> $stable(tx.margin_code);
   endproperty
   a_hold: assert property (p_hold)
      else $error("margin changed without recovery lock");

   property p_apply;
      ltssm.rcvr_lock |=> tx.margin_code == $past(st.margin_sel);
   endproperty
   a_apply: assert property (p_apply)
      else $error("margin not applied at recovery lock");

   property p_mod;
      ltssm.in_pol_comp && st.mc && warm_rst_n |=> tx.mod_pattern;
   endproperty
   a_mod: assert property (p_mod)
      else $error("modified pattern not selected");

   property p_skp;
      !ltssm.in_pol_comp ##1 ltssm.in_pol_comp |-> !tx.skip_insert;
   endproperty
   a_skp: assert property (p_skp)
      else $error("skip insert outside compliance");

   property p_de;
      ltssm.in_pol_comp && ltssm.comp_via_force && warm_rst_n |=>
         tx.deemph_override && tx.deemph_35db == $past(st.de);
   endproperty
   a_de: assert property (p_de)
      else $error("compliance de-emphasis wrong");

   property p_resv;
      setup && !pwrite && paddr == 12'h070 |=>
         prdata[15:13] == 3'h0 && prdata[6:0] == 7'h0;
   endproperty
   a_resv: assert property (p_resv)
      else $error("reserved bits read nonzero");

   property p_sticky;
      !warm_rst_n && !psel && !ltssm.enter_pol_cfg |=>
         $stable(st.margin_sel) && $stable(st.de) && $stable(st.mc);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("sticky field lost on warm reset");

   c_write: cover property (wr && paddr == 12'h070);
   c_apply: cover property (ltssm.rcvr_lock && st.margin_sel != st.applied);
   c_force: cover property (tx.deemph_override && tx.deemph_35db);
   c_err: cover property (pslverr && pready);
endmodule

// ---- verilog/plcm_map.svh ----
// Offsets, field positions, reset values and voltage codes of the
// link compliance and margin control block.
// Assumes byte addressing on a 12-bit APB address.
`ifndef PLCM_MAP_SVH
`define PLCM_MAP_SVH

// Register byte offsets
`define PLCM_LCTL2_OFS 12'h070
`define PLCM_STAT_OFS 12'h100

// Field positions in link_control_two
`define PLCM_TM_LSB 7
`define PLCM_TM_MSB 9
`define PLCM_MC_BIT 10
`define PLCM_SKP_BIT 11
`define PLCM_DE_BIT 12

// Reset values
`define PLCM_TM_RST 3'h0
`define PLCM_BIT_RST 1'h0

// Margin codes
`define PLCM_TM_NORMAL 3'h0
`define PLCM_TM_LAST 3'h5

// Full-swing and low-swing voltages in mV for codes 1 to 5
`define PLCM_FS1 10'h384
`define PLCM_LS1 10'h1f4
`define PLCM_FS2 10'h2bc
`define PLCM_LS2 10'h190
`define PLCM_FS3 10'h1f4
`define PLCM_LS3 10'h12c
`define PLCM_FS4 10'h12c
`define PLCM_LS4 10'h0c8
`define PLCM_FS5 10'h0c8
`define PLCM_LS5 10'h064
`define PLCM_MV_NONE 10'h000

`endif

// ---- verilog/plcm_pkg.sv ----
// Types of the link compliance and margin control block.
// Assumes nothing beyond the map header.
package plcm_pkg;

   // Events and levels reported by the link training state machine
   typedef struct packed {
      logic enter_pol_cfg;  // Pulse: entering Polling.Configuration
      logic rcvr_lock;      // Pulse: passing Recovery.RcvrLock
      logic in_pol_comp;    // Level: in Polling.Compliance
      logic comp_via_force; // Level: compliance reached by forcing
   } plcm_ltssm_t;

   // Settings handed to the transmitter and state machine
   typedef struct packed {
      logic [2:0] margin_code;
      logic [9:0] full_mv;
      logic [9:0] low_mv;
      logic use_lane_drive;
      logic mod_pattern;
      logic skip_insert;
      logic deemph_override;
      logic deemph_35db;
   } plcm_tx_t;

   // Whole state of the block
   typedef struct packed {
      logic [2:0] margin_sel;
      logic mc;
      logic skp;
      logic de;
      logic [2:0] applied;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      plcm_tx_t tx;
   } plcm_state_t;

endpackage

// ---- bench/plcm_ltssm_model.sv ----
// Behavioural link training state machine feeding the control block.
// Assumes the bench calls its tasks; all changes land just after a
// rising edge of pclk.
`timescale 1ns/1ps

module plcm_ltssm_model (
   // Clock
   input wire logic pclk,
   // Events and levels toward the block
   output plcm_pkg::plcm_ltssm_t ltssm
);
   import plcm_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Idle until the bench asks for an event
   initial ltssm = '0;

   // One-cycle event: 1 passes Recovery.RcvrLock, 0 enters
   // Polling.Configuration; a retrain after a margin change
   task automatic pulse(input logic lock);
      @(posedge pclk);
      ltssm.rcvr_lock <= lock;
      ltssm.enter_pol_cfg <= ~lock;
      @(posedge pclk);
      ltssm.rcvr_lock <= 1'b0;
      ltssm.enter_pol_cfg <= 1'b0;
   endtask

   // Compliance levels; forced entry mimics both ends forcing it
   task automatic comp(input logic on, input logic forced);
      @(posedge pclk);
      ltssm.in_pol_comp <= on;
      ltssm.comp_via_force <= forced;
   endtask
endmodule

// ---- bench/test_plcm_ctl.sv ----
// Self-checking bench for the margin and compliance controls.
// Assumes the design files and the state machine model compile first.
`timescale 1ns/1ps
`include "plcm_map.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
bad_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

module test_plcm_ctl;
   import plcm_pkg::*;
   logic pclk = 0, presetn = 0, warm_rst_n = 1, psel = 0, penable = 0;
   logic pwrite = 0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [3:0] pstrb = 4'h3;
   logic [32:0] expq[$], e;
   plcm_ltssm_t ltssm;
   plcm_tx_t tx;
   int bad_count = 0, total_checks = 0, cyc = 0;
   logic [9:0] fs[8] = '{10'h000, 10'h384, 10'h2bc, 10'h1f4, 10'h12c,
      10'h0c8, 10'h000, 10'h000};
   logic [9:0] ls[8] = '{10'h000, 10'h1f4, 10'h190, 10'h12c, 10'h0c8,
      10'h064, 10'h000, 10'h000};

   plcm_ctl u_plcm_ctl (.pclk(pclk), .presetn(presetn),
      .warm_rst_n(warm_rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ltssm(ltssm),
      .tx(tx));
   plcm_ltssm_model u_plcm_ltssm_model (.pclk(pclk), .ltssm(ltssm));

   ////////////////////////////////////////////////////////////////////
   always #2 pclk = ~pclk;

   // Read monitor pops the oldest note; also cuts a hang short
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 5000) begin
         bad_count++;
         test_done();
      end else if (psel && penable && pready === 1'b1 && !pwrite) begin
         e = expq.pop_front();
         `CHK("read", e, {pslverr, prdata})
      end
   end

   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] x);
      expq.push_back(x);
      apb(1'b0, a, 32'h0);
   endtask

   // Applied margin and its decoded drive level
   task automatic txchk(input logic [2:0] c);
      @(posedge pclk);
      #1;
      `CHK("code", c, tx.margin_code)
      `CHK("full", fs[c], tx.full_mv)
      `CHK("low", ls[c], tx.low_mv)
      `CHK("lane", (c == 3'h0 || c > 3'h5), tx.use_lane_drive)
   endtask

   // Mode bits toward the state machine
   task automatic mchk(input logic [3:0] x);
      @(posedge pclk);
      #1;
      `CHK("mod", x[3], tx.mod_pattern)
      `CHK("skp", x[2], tx.skip_insert)
      `CHK("ovr", x[1], tx.deemph_override)
      `CHK("db35", x[0], tx.deemph_35db)
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'h16fbcb06));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(`PLCM_LCTL2_OFS, 33'h0);
      txchk(3'h0);
      $display("test reset done");
      // Every code, random junk in reserved bits; old level holds until lock
      for (int k = 0; k < 8; k++) begin
         r = $urandom();
         apb(1'b1, `PLCM_LCTL2_OFS, (r & 32'hffffe07f) | (32'(k) << 7));
         rd(`PLCM_LCTL2_OFS, {1'b0, 32'(k) << 7});
         txchk(3'(k - 1) & {3{k != 0}});
         u_plcm_ltssm_model.pulse(1'b1);
         txchk(3'(k));
      end
      $display("test margin done");
      // Reserved bits, then clear on Polling.Configuration
      apb(1'b1, `PLCM_LCTL2_OFS, 32'hffffffff);
      rd(`PLCM_LCTL2_OFS, 33'h1f80);
      u_plcm_ltssm_model.pulse(1'b0);
      rd(`PLCM_LCTL2_OFS, 33'h1c00);
      // Status: applied 7 on lane drive, written code differs
      rd(`PLCM_STAT_OFS, 33'h02f);
      txchk(3'h7);
      u_plcm_ltssm_model.pulse(1'b1);
      txchk(3'h0);
      $display("test clear done");
      // Compliance modes, normal and forced entry
      u_plcm_ltssm_model.comp(1'b1, 1'b0);
      mchk(4'hd);
      u_plcm_ltssm_model.comp(1'b1, 1'b1);
      mchk(4'hf);
      // Status shows the live compliance level
      rd(`PLCM_STAT_OFS, 33'h018);
      apb(1'b1, `PLCM_LCTL2_OFS, 32'h0c00);
      mchk(4'he);
      // Warm reset drops modes but keeps the register
      @(posedge pclk) warm_rst_n <= 1'b0;
      repeat (2) @(posedge pclk);
      mchk(4'h0);
      @(posedge pclk) warm_rst_n <= 1'b1;
      rd(`PLCM_LCTL2_OFS, 33'h0c00);
      u_plcm_ltssm_model.comp(1'b0, 1'b0);
      mchk(4'h0);
      $display("test compliance done");
      rd(12'h004, {1'b1, 32'h0});
      // Byte strobes split the margin field; status ignores writes
      pstrb <= 4'h1;
      apb(1'b1, `PLCM_LCTL2_OFS, 32'hffffffff);
      rd(`PLCM_LCTL2_OFS, 33'h0c80);
      pstrb <= 4'h2;
      apb(1'b1, `PLCM_LCTL2_OFS, 32'h0);
      rd(`PLCM_LCTL2_OFS, 33'h0080);
      pstrb <= 4'h3;
      apb(1'b1, `PLCM_STAT_OFS, 32'hffffffff);
      rd(`PLCM_STAT_OFS, 33'h028);
      // Leave debug fields at their defaults
      apb(1'b1, `PLCM_LCTL2_OFS, 32'h0);
      $display("test unmapped done");
      test_done();
   end
endmodule
